// file: design/mfc_fault_check.sv
// Contract
// - word access needs both low bits zero
// - halfword needs bit 0 zero; bytes unchecked
// - alignment on data only, own enable
// - translation checks only with unit enabled
// - level one low bits 00 faults
// - coarse 00/11 or fine 00 faults
// - domain field bit 0 clear faults
// - section domain at L1, page at L2
// - domain write discards unlocked entries
// - permission check only for client domains
// - section perm at L1, page at L2
// - violation blocks bus and aborts core
// - data fault stores domain and address
// - fetch fault updates status, pipelined onward
// - report only highest priority source
// - alignment 0001, miss 0000, L1 1100
// - L2 1110, section 0101, page 0111
// - domain, permission, external, debug codes
// - domain invalid for early faults
// - burst aborts on first or page-crossing beat
// - bus aborts honoured only on listed accesses
// - aborted swap read cancels write
// - fetch side prefetch, data side data abort
//
// Added by the designer: the placing of the registers and strobed register access.
module mfc_fault_check
    import mfc_pkg::*;
#(
    parameter int PIPE_STAGES = 3
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic acc_valid,
    input wire mfc_access_t acc,
    input wire logic l1_valid,
    input wire mfc_walk_t l1,
    input wire logic l2_valid,
    input wire mfc_walk_t l2,
    input wire logic perm_fail,
    input wire logic beat_valid,
    input wire mfc_beat_t beat,
    input wire logic pipe_advance,
    input wire logic pipe_flush,
    output logic data_abort,
    output logic prefetch_abort,
    output logic bus_block,
    output logic swap_write_cancel,
    output logic tlb_flush_unlocked
);

    logic [1:0] ctrl_q;
    logic [31:0] domain_permission_register_q;
    logic [8:0] dfsr_q;
    logic [31:0] fault_address_capture_q;
    logic [3:0] ifsr_q;
    logic [31:0] rdata_q;
    logic is_data_q;
    logic swap_q;
    logic [31:0] vaddr_q;
    logic [3:0] domain_q;
    logic lock_q;
    logic [MFC_PAGE_SHIFT-1:0] page_unused_q;
    logic [31-MFC_PAGE_SHIFT:0] page_q;
    logic dabort_q;
    logic block_q;
    logic swap_cancel_q;
    logic flush_q;
    logic [PIPE_STAGES-1:0] pipe_q;

    // register decode
    wire wr_ctrl = reg_wr && (reg_addr == MFC_CTRL_OFS);
    wire wr_domain = reg_wr && (reg_addr == MFC_DOMAIN_OFS);
    wire mmu_en = ctrl_q[MFC_CTRL_MMU_EN_BIT];
    wire align_en = ctrl_q[MFC_CTRL_ALIGN_EN_BIT];
    logic [31:0] rd_mux;
    assign rd_mux =
        (reg_addr == MFC_CTRL_OFS) ? {30'h0, ctrl_q} :
        (reg_addr == MFC_DOMAIN_OFS) ? domain_permission_register_q :
        (reg_addr == MFC_DFSR_OFS) ? {23'h0, dfsr_q} :
        (reg_addr == MFC_FAR_OFS) ? fault_address_capture_q :
        (reg_addr == MFC_IFSR_OFS) ? {28'h0, ifsr_q} : 32'h0;

    // current access side: a new request overrides the latched one
    wire cur_data = acc_valid ? acc.is_data : is_data_q;
    wire cur_swap = acc_valid ? acc.swap : swap_q;
    wire [31:0] cur_va = acc_valid ? acc.vaddr : vaddr_q;
    wire locked = lock_q && !acc_valid;

    wire mis_word = (acc.size == MFC_SIZE_WORD) && (acc.vaddr[1:0] != 2'h0);
    wire mis_half = (acc.size == MFC_SIZE_HALF) && acc.vaddr[0];
    // data only, gated by its own enable
    wire f_align = acc_valid && acc.is_data && align_en
        && (mis_word || mis_half);

    // level one and level two descriptor decode
    wire [3:0] l1_dom = l1.desc[MFC_L1_DOMAIN_LSB +: 4];
    wire l1_ok = l1_valid && !l1.ext_abort && mmu_en;
    wire l1_section = l1.desc[1:0] == MFC_DESC_L1_SECTION;
    wire [1:0] l1_field = domain_permission_register_q[{l1_dom, 1'b0} +: 2];
    wire [1:0] l2_field = domain_permission_register_q[{domain_q, 1'b0} +: 2];
    wire l2_ok = l2_valid && !l2.ext_abort && mmu_en;
    wire l2_bad_coarse = (l2.desc[1:0] == MFC_DESC_INVALID)
        || (l2.desc[1:0] == MFC_DESC_COARSE_BAD);
    wire l2_bad_fine = l2.desc[1:0] == MFC_DESC_INVALID;

    // honour bus abort on first beat or 1KB crossing
    wire page_cross = beat.addr[31:MFC_PAGE_SHIFT] != page_q;
    // only aborts on accesses that can take them
    wire beat_class = beat.noncached_read || beat.unbuffered_write
        || beat.locked_swap_nc;

    logic [MFC_NSRC-1:0] src;
    // translation, domain, permission need the unit enabled
    assign src[MFC_SRC_ALIGN] = f_align;
    assign src[MFC_SRC_TLBMISS] = acc_valid && acc.tlb_miss && mmu_en;
    assign src[MFC_SRC_EXT_L1] = l1_valid && l1.ext_abort;
    assign src[MFC_SRC_EXT_L2] = l2_valid && l2.ext_abort;
    assign src[MFC_SRC_TR_SEC] = l1_ok && (l1.desc[1:0] == MFC_DESC_INVALID);
    assign src[MFC_SRC_TR_PAGE] = l2_ok
        && (l2.coarse ? l2_bad_coarse : l2_bad_fine);
    // section domain checked at level one return
    assign src[MFC_SRC_DOM_SEC] = l1_ok && l1_section && !l1_field[0];
    // page domain checked at level two return
    assign src[MFC_SRC_DOM_PAGE] = l2_ok && !l2_field[0];
    assign src[MFC_SRC_PERM_SEC] = l1_ok && l1_section
        && (l1_field == MFC_DOMAIN_CLIENT) && perm_fail;
    assign src[MFC_SRC_PERM_PAGE] = l2_ok
        && (l2_field == MFC_DOMAIN_CLIENT) && perm_fail;
    assign src[MFC_SRC_EXT_BUS] = beat_valid && beat.ext_abort && beat_class
        && (beat.first || page_cross);
    assign src[MFC_SRC_DEBUG] = acc_valid && acc.debug;

    // pick the highest priority source only
    logic [3:0] win_status;
    logic win_dom_valid;
    always_comb
    begin
        win_status = 4'h0;
        win_dom_valid = 1'b0;
        for (int i = MFC_NSRC - 1; i >= 0; i--)
        begin
            if (src[i])
            begin
                win_status = MFC_STATUS_TABLE[i*4 +: 4];
                win_dom_valid = !MFC_DOM_INVALID_MASK[i];
            end
        end
    end

    // all later sources stay masked until a new access request arrives
    wire report = (|src) && !locked;
    wire rep_data = report && cur_data;
    wire rep_inst = report && !cur_data;
    wire [3:0] rep_dom = l1_valid ? l1_dom : domain_q;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= MFC_CTRL_RESET;
            domain_permission_register_q <= MFC_DOMAIN_RESET;
            rdata_q <= 32'h0;
            flush_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= reg_wdata[1:0];
            if (wr_domain)
                domain_permission_register_q <= reg_wdata;
            rdata_q <= reg_rd ? rd_mux : 32'h0;
            // discard unlocked entries after a domain write
            flush_q <= wr_domain;
        end
    end

    // access context
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            is_data_q <= 1'b0;
            swap_q <= 1'b0;
            vaddr_q <= 32'h0;
            domain_q <= 4'h0;
            page_q <= '0;
        end
        else
        begin
            if (acc_valid)
            begin
                is_data_q <= acc.is_data;
                swap_q <= acc.swap;
                vaddr_q <= acc.vaddr;
            end
            if (l1_valid)
                domain_q <= l1_dom;
            if (beat_valid)
                page_q <= beat.addr[31:MFC_PAGE_SHIFT];
        end
    end

    // fault reporting
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock_q <= 1'b0;
            dabort_q <= 1'b0;
            block_q <= 1'b0;
            swap_cancel_q <= 1'b0;
            dfsr_q <= 9'h0;
            fault_address_capture_q <= 32'h0;
            ifsr_q <= 4'h0;
        end
        else
        begin
            lock_q <= report || locked;
            // keep the bus access blocked for this access
            block_q <= report || (block_q && !acc_valid);
            // aborted swap read cancels its write
            swap_cancel_q <= (report && cur_swap)
                || (swap_cancel_q && !acc_valid);
            // data side raises a data abort
            dabort_q <= rep_data;
            // data side captures domain, status, address
            if (rep_data)
            begin
                dfsr_q[MFC_DFSR_DOM_LSB +: 4] <= rep_dom;
                dfsr_q[MFC_DFSR_STAT_LSB +: 4] <= win_status;
                dfsr_q[MFC_DFSR_DVALID_BIT] <= win_dom_valid;
                fault_address_capture_q <= cur_va;
            end
            if (rep_inst)
                ifsr_q <= win_status;
        end
    end

    // prefetch abort rides the pipe to execute
    genvar g;
    generate
        for (g = 0; g < PIPE_STAGES; g++)
        begin : g_pipe
            logic feed;
            if (g == 0)
            begin : g_head
                assign feed = rep_inst || (pipe_q[0] && !pipe_advance);
            end
            else
            begin : g_body
                assign feed = pipe_advance ? pipe_q[g-1] : pipe_q[g];
            end
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                    pipe_q[g] <= 1'b0;
                else
                    pipe_q[g] <= feed && !pipe_flush;
            end
        end
    endgenerate

    assign reg_rdata = rdata_q;
    assign data_abort = dabort_q;
    assign prefetch_abort = pipe_q[PIPE_STAGES-1];
    assign bus_block = block_q;
    assign swap_write_cancel = swap_cancel_q;
    assign tlb_flush_unlocked = flush_q;

endmodule // mfc_fault_check

// file: design/mfc_pkg.sv
package mfc_pkg;

    // register byte offsets
    localparam logic [7:0] MFC_CTRL_OFS = 8'h00;
    localparam logic [7:0] MFC_DOMAIN_OFS = 8'h04;
    localparam logic [7:0] MFC_DFSR_OFS = 8'h08;
    localparam logic [7:0] MFC_FAR_OFS = 8'h0C;
    localparam logic [7:0] MFC_IFSR_OFS = 8'h10;

    // control register fields
    localparam int MFC_CTRL_MMU_EN_BIT = 0;
    localparam int MFC_CTRL_ALIGN_EN_BIT = 1;
    localparam logic [1:0] MFC_CTRL_RESET = 2'h0;
    localparam logic [31:0] MFC_DOMAIN_RESET = 32'h0000_0000;

    // data fault status layout: domain, status, domain valid
    localparam int MFC_DFSR_DOM_LSB = 0;
    localparam int MFC_DFSR_STAT_LSB = 4;
    localparam int MFC_DFSR_DVALID_BIT = 8;

    // access size codes
    localparam logic [1:0] MFC_SIZE_BYTE = 2'h0;
    localparam logic [1:0] MFC_SIZE_HALF = 2'h1;
    localparam logic [1:0] MFC_SIZE_WORD = 2'h2;

    // descriptor fields
    localparam logic [1:0] MFC_DESC_INVALID = 2'h0;
    localparam logic [1:0] MFC_DESC_L1_SECTION = 2'h2;
    localparam logic [1:0] MFC_DESC_COARSE_BAD = 2'h3;
    localparam int MFC_L1_DOMAIN_LSB = 5;
    localparam logic [1:0] MFC_DOMAIN_CLIENT = 2'h1;

    // smallest page used to filter bus aborts
    localparam int MFC_PAGE_SHIFT = 10;

    // fault sources, index 0 is the highest priority
    localparam int MFC_NSRC = 12;
    localparam int MFC_SRC_ALIGN = 0;
    localparam int MFC_SRC_TLBMISS = 1;
    localparam int MFC_SRC_EXT_L1 = 2;
    localparam int MFC_SRC_EXT_L2 = 3;
    localparam int MFC_SRC_TR_SEC = 4;
    localparam int MFC_SRC_TR_PAGE = 5;
    localparam int MFC_SRC_DOM_SEC = 6;
    localparam int MFC_SRC_DOM_PAGE = 7;
    localparam int MFC_SRC_PERM_SEC = 8;
    localparam int MFC_SRC_PERM_PAGE = 9;
    localparam int MFC_SRC_EXT_BUS = 10;
    localparam int MFC_SRC_DEBUG = 11;

    // status codes in source order
    localparam logic [47:0] MFC_STATUS_TABLE = {
        4'h2, 4'hA, 4'hF, 4'hD, 4'hB, 4'h9,
        4'h7, 4'h5, 4'hE, 4'hC, 4'h0, 4'h1
    };
    // sources raised before a domain was read
    localparam logic [11:0] MFC_DOM_INVALID_MASK = 12'h017;

    typedef struct packed {
        logic is_data;
        logic [1:0] size;
        logic swap;
        logic tlb_miss;
        logic debug;
        logic [31:0] vaddr;
    } mfc_access_t;

    typedef struct packed {
        logic ext_abort;
        logic coarse;
        logic [31:0] desc;
    } mfc_walk_t;

    typedef struct packed {
        logic first;
        logic ext_abort;
        logic noncached_read;
        logic unbuffered_write;
        logic locked_swap_nc;
        logic [31:0] addr;
    } mfc_beat_t;

endpackage

// file: dv/mfc_core_model.sv
module mfc_core_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic prefetch_abort,
    output logic pipe_advance,
    output logic pipe_flush
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flush_q;
    assign pipe_advance = run && !flush_q;
    assign pipe_flush = flush_q;
    // exception taken: flush behind a prefetch abort
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            flush_q <= 1'b0;
        else
            flush_q <= prefetch_abort && !flush_q;
    end
endmodule // mfc_core_model

// file: dv/mfc_fault_check_props.sv
module mfc_fault_check_props
    import mfc_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic acc_valid,
    input wire mfc_access_t acc,
    input wire logic l1_valid,
    input wire mfc_walk_t l1,
    input wire logic pipe_advance,
    input wire logic pipe_flush,
    input wire logic data_abort,
    input wire logic prefetch_abort,
    input wire logic bus_block,
    input wire logic swap_write_cancel,
    input wire logic tlb_flush_unlocked
);
    timeunit 1ns;
    timeprecision 1ns;
    logic aen_q;
    logic men_q;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // shadow of the enable bits
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            {aen_q, men_q} <= 2'h0;
        else if (reg_wr && reg_addr == MFC_CTRL_OFS)
            {aen_q, men_q} <= reg_wdata[1:0];
    end

    property p_word;
        acc_valid && acc.is_data && aen_q && acc.size == MFC_SIZE_WORD
            && acc.vaddr[1:0] != 2'h0 |=> data_abort && bus_block;
    endproperty
    a_word: assert property (p_word) else $error("word align");
    property p_half;
        acc_valid && acc.is_data && aen_q && acc.size == MFC_SIZE_HALF
            && acc.vaddr[0] |=> data_abort;
    endproperty
    a_half: assert property (p_half) else $error("half align");
    property p_off;
        l1_valid && !men_q && !l1.ext_abort |=> !data_abort;
    endproperty
    a_off: assert property (p_off) else $error("abort while off");
    property p_abort;
        data_abort |-> bus_block ##1 !data_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort shape");
    property p_swap;
        swap_write_cancel |-> bus_block;
    endproperty
    a_swap: assert property (p_swap) else $error("cancel alone");
    property p_flush;
        reg_wr && reg_addr == MFC_DOMAIN_OFS |=>
            tlb_flush_unlocked ##1 !tlb_flush_unlocked;
    endproperty
    a_flush: assert property (p_flush) else $error("no flush");
    property p_pre;
        $rose(prefetch_abort) |-> $past(pipe_advance);
    endproperty
    a_pre: assert property (p_pre) else $error("early prefetch");
    property p_pflush;
        pipe_flush |=> !prefetch_abort;
    endproperty
    a_pflush: assert property (p_pflush) else $error("flush kept");
endmodule // mfc_fault_check_props

bind mfc_fault_check mfc_fault_check_props u_props (.core_clk, .arst_n,
    .reg_addr, .reg_wdata, .reg_wr, .acc_valid, .acc, .l1_valid, .l1,
    .pipe_advance, .pipe_flush, .data_abort, .prefetch_abort, .bus_block,
    .swap_write_cancel, .tlb_flush_unlocked);

// file: dv/tb_top.sv
module tb_top
    import mfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic acc_valid = 1'b0;
    logic l1_valid = 1'b0;
    logic l2_valid = 1'b0;
    logic beat_valid = 1'b0;
    logic perm_fail = 1'b0;
    logic run = 1'b0;
    mfc_access_t acc = '0;
    mfc_walk_t l1 = '0;
    mfc_walk_t l2 = '0;
    mfc_beat_t beat = '0;
    logic [31:0] reg_rdata, va;
    logic data_abort, prefetch_abort, bus_block, swap_write_cancel;
    logic tlb_flush_unlocked, pipe_advance, pipe_flush, fl, ex;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;

    mfc_fault_check #(.PIPE_STAGES(3)) uut (.core_clk, .arst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_valid, .acc, .l1_valid,
        .l1, .l2_valid, .l2, .perm_fail, .beat_valid, .beat, .pipe_advance,
        .pipe_flush, .data_abort, .prefetch_abort, .bus_block,
        .swap_write_cancel, .tlb_flush_unlocked);
    mfc_core_model u_core (.core_clk, .arst_n, .run, .prefetch_abort,
        .pipe_advance, .pipe_flush);

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] s, e, input string w);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", w, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1 fl = tlb_flush_unlocked;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hFFFF_FFFF);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, e, "reg_rdata");
        @(posedge core_clk);
    endtask
    task automatic go(input logic e);
        @(posedge core_clk);
        {acc_valid, l1_valid, l2_valid, beat_valid, perm_fail} <= 5'h0;
        #1 chk(data_abort, e, "data_abort");
        @(posedge core_clk);
    endtask
    task automatic ac(input logic [1:0] sz, input logic [31:0] a,
        input logic [1:0] f = 2'h0, input logic d = 1'b1, s = 1'b0);
        acc_valid <= 1'b1;
        acc <= {d, sz, s, f, a};
    endtask
    task automatic bt(input logic fs, e, input logic [2:0] f,
        input logic [31:0] a);
        beat_valid <= 1'b1;
        beat <= {fs, e, f, a};
    endtask
    task automatic wk(input logic two, input logic [32:0] d1,
        input logic [33:0] d2, input logic pf, input logic [31:0] e,
        input logic [31:0] m = 32'hFFFF_FFFF);
        ac(MFC_SIZE_WORD, 32'h4000);
        go(1'b0);
        l1_valid <= 1'b1;
        l1 <= {d1[32], 1'b0, d1[31:0]};
        perm_fail <= pf && !two;
        go(!two);
        if (two)
        begin
            l2_valid <= 1'b1;
            l2 <= d2;
            perm_fail <= pf;
            go(1'b1);
        end
        rd(MFC_DFSR_OFS, e, m);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        wr(MFC_CTRL_OFS, 32'h2);
        for (int s = 0; s < 3; s++)
        begin
            for (int b = 0; b < 4; b++)
            begin
                va = 32'h1230 + b;
                ex = (s == 2 && b != 0) || (s == 1 && b[0]);
                ac(2'(s), va);
                go(ex);
                if (ex)
                begin
                    rd(MFC_DFSR_OFS, 32'h10);
                    rd(MFC_FAR_OFS, va);
                end
            end
        end
        ac(MFC_SIZE_WORD, 32'h4000);
        go(1'b0);
        l1_valid <= 1'b1;
        l1 <= '0;
        go(1'b0);
        rd(MFC_DFSR_OFS, 32'h10);
        $display("done alignment");
        // no locked entries while domains change
        wr(MFC_DOMAIN_OFS, 32'h10);
        chk(fl, 32'h1, "flush");
        wr(MFC_CTRL_OFS, 32'h3);
        chk(fl, 32'h0, "flush");
        wk(1'b0, 33'h0, 34'h0, 1'b0, 32'h50, 32'h1F0);
        wk(1'b0, 33'h62, 34'h0, 1'b0, 32'h193);
        wk(1'b0, 33'h42, 34'h0, 1'b1, 32'h1D2);
        wk(1'b0, 33'h1_0000_0042, 34'h0, 1'b0, 32'hC0, 32'h1F0);
        wk(1'b1, 33'h41, 34'h1_0000_0003, 1'b0, 32'h172);
        wk(1'b1, 33'h61, 34'h1_0000_0000, 1'b0, 32'h173);
        wk(1'b1, 33'h43, 34'h0, 1'b0, 32'h172);
        wk(1'b1, 33'h63, 34'h2, 1'b0, 32'h1B3);
        wk(1'b1, 33'h41, 34'h1_0000_0002, 1'b1, 32'h1F2);
        wk(1'b1, 33'h41, 34'h3_0000_0002, 1'b0, 32'h1E2);
        ac(MFC_SIZE_WORD, 32'h5000, 2'h2);
        go(1'b1);
        rd(MFC_DFSR_OFS, 32'h0, 32'h1F0);
        ac(MFC_SIZE_WORD, 32'h5002, 2'h3);
        go(1'b1);
        rd(MFC_DFSR_OFS, 32'h10, 32'h1F0);
        ac(MFC_SIZE_WORD, 32'h5004, 2'h1);
        go(1'b1);
        rd(MFC_DFSR_OFS, 32'h20, 32'hF0);
        $display("done walk faults");
        for (int k = 0; k < 4; k++)
        begin
            ac(MFC_SIZE_WORD, 32'h100);
            go(1'b0);
            bt(1'b1, 1'b1, 3'((4'h1 << k) >> 1), 32'h100);
            go(k != 0);
        end
        ac(MFC_SIZE_WORD, 32'h3E0);
        go(1'b0);
        for (va = 32'h3E0; va <= 32'h400; va += 32'h8)
        begin
            bt(va == 32'h3E0, va != 32'h3E0, 3'h4, va);
            go(va == 32'h400);
        end
        rd(MFC_DFSR_OFS, 32'hA0, 32'hF0);
        ac(MFC_SIZE_WORD, 32'h600, 2'h0, 1'b1, 1'b1);
        go(1'b0);
        bt(1'b1, 1'b1, 3'h1, 32'h600);
        go(1'b1);
        #1 chk(swap_write_cancel, 32'h1, "cancel");
        @(posedge core_clk);
        $display("done bus aborts");
        ac(MFC_SIZE_WORD, 32'h7000, 2'h2, 1'b0);
        go(1'b0);
        rd(MFC_FAR_OFS, 32'h600);
        run <= 1'b1;
        fl = 1'b0;
        repeat (6)
        begin
            @(posedge core_clk);
            #1 fl |= prefetch_abort;
        end
        chk(fl, 32'h1, "prefetch_abort");
        @(posedge core_clk);
        run <= 1'b0;
        $display("done prefetch");
        finish_test();
    end
endmodule // tb_top
